// file: pkg/rtc_pkg.sv
// Types shared by the calendar clock modules.
package rtc_pkg;
	typedef logic [3:0] nibble_t;
	typedef logic [7:0] bcd2_t;
	typedef enum {BUS_IDLE, BUS_LATCH, BUS_WRITE, BUS_READ} bus_mode_t;
endpackage

// file: pkg/rtc_regs.svh
// Digit offsets, field positions, reset values and timing counts of the nibble bus calendar clock.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ----------------------------------------------------------------------------
// Digit offsets
// ----------------------------------------------------------------------------
`define RTC_SECONDS_UNITS     4'h0
`define RTC_SECONDS_TENS      4'h1
`define RTC_MINUTES_UNITS     4'h2
`define RTC_MINUTES_TENS      4'h3
`define RTC_HOURS_UNITS       4'h4
`define RTC_HOURS_TENS_FORMAT 4'h5
`define RTC_SEVEN_DAY_CYCLE   4'h6
`define RTC_DATE_UNITS        4'h7
`define RTC_DATE_TENS_LEAP    4'h8
`define RTC_MONTH_UNITS       4'h9
`define RTC_MONTH_TENS        4'hA
`define RTC_YEAR_UNITS        4'hB
`define RTC_YEAR_TENS         4'hC
`define RTC_CODE_DIV_RESET    4'hD
`define RTC_CODE_REF_LOW      4'hE
`define RTC_DIGIT_COUNT       13

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RTC_HT_PM_BIT         2
`define RTC_HT_24H_BIT        3
`define RTC_LEAP_LO_BIT       2
`define RTC_LEAP_HI_BIT       3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RTC_RESET_DIGIT       4'h0
`define RTC_RESET_DAY_UNITS   4'h1
`define RTC_RESET_MONTH_UNITS 4'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTC_XTAL_HZ           32768
`define RTC_DIV_STAGES        15
`define RTC_DIV_RESET_STAGES  5
`define RTC_SQ_STAGE          4
`define RTC_BUSY_US           244
`define RTC_REF_PULSE_NS      122100

`endif

// file: pkg/timebase_if.sv
// Carrier between the timebase and the calendar core.
`timescale 1ns/10ps
interface timebase_if;
	logic sec_edge;
	logic sq_1024;
	logic pulse_on;
	logic busy_n;
	logic clr_req;
	modport source (output sec_edge, output sq_1024, output pulse_on, output busy_n, input clr_req);
	modport sink   (input sec_edge, input sq_1024, input pulse_on, input busy_n, output clr_req);
endinterface

// file: src/nibble_bus_rtc_calendar.sv
// Calendar clock with a multiplexed nibble bus: top level, digit store and bus control.
// Contract
// - Address and data share one nibble bus.
// - Hours tens bit2 is PM, bit3 24-hour.
// - Writing 24-hour mode clears the PM bit.
// - Date tens bits 2 and 3 pick leap phase.
// - Write to code D resets divider tail, busy.
// - Read of code E or F gives reference signals.
// - Missing digit bits read zero, writes dropped.
// - Format and leap bits are readable and writable.
// - Bus enabled only with both selects high.
// - Selects low: ignore strobes, release data lines.
// - Write strobe is level; data flows while high.
// - Latch and read act on level.
// - One second derived from crystal by dividers.
// - Calendar rolls month ends, including leap February.
// - Busy low after digits count each second.
// - Stop input high with both selects high freezes the digit count.
// - Reference bits: 1024 Hz, 1 Hz, minute, hour.
`timescale 1ns/10ps
`include "rtc_regs.svh"
module nibble_bus_rtc_calendar (
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_ce,
	input  wire logic             i_xt,
	input  wire logic             i_power_detect_select,
	input  wire logic             i_host_select,
	input  wire logic             i_write,
	input  wire logic             i_read,
	input  wire logic             i_addr_latch,
	input  wire logic             i_stop,
	input  wire rtc_pkg::nibble_t i_nibble_bus,
	output rtc_pkg::nibble_t      o_nibble_bus,
	output logic                  o_nibble_oe,
	output logic                  o_busy_n
);
	import rtc_pkg::*;

	// ----------------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------------
	// Two digit BCD step: returns carry, tens and units.
	function automatic logic [8:0] step2(input nibble_t u, input nibble_t t, input bcd2_t last, input bcd2_t first);
		if ({t, u} == last)
			step2 = {1'b1, first};
		else if (u == 4'h9)
			step2 = {1'b0, t + 4'h1, 4'h0};
		else
			step2 = {1'b0, t, u + 4'h1};
	endfunction

	// Bits that exist in each digit; the others read zero and drop writes.
	function automatic nibble_t digit_mask(input nibble_t a);
		if (a == `RTC_SECONDS_TENS || a == `RTC_MINUTES_TENS || a == `RTC_SEVEN_DAY_CYCLE)
			digit_mask = 4'h7;
		else if (a == `RTC_MONTH_TENS)
			digit_mask = 4'h1;
		else if (a > `RTC_YEAR_TENS)
			digit_mask = 4'h0;
		else
			digit_mask = 4'hF;
	endfunction

	function automatic bcd2_t days_in_month(input bcd2_t mo, input logic leap);
		if (mo == 8'h02)
			days_in_month = leap ? 8'h29 : 8'h28;
		else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11)
			days_in_month = 8'h30;
		else
			days_in_month = 8'h31;
	endfunction

	// Year modulo four from BCD, compared with the phase that the two select bits give.
	function automatic logic is_leap(input nibble_t y10, input nibble_t y1, input logic [1:0] sel);
		logic [1:0] rem;
		logic [1:0] phase;
		rem = 2'({y10[0], 1'b0} + y1[1:0]);
		if (sel == 2'b00)
			phase = 2'h0;
		else if (sel == 2'b01)
			phase = 2'h3;
		else if (sel == 2'b10)
			phase = 2'h2;
		else
			phase = 2'h1;
		is_leap = rem == phase;
	endfunction

	// ----------------------------------------------------------------------------
	// Pin synchronisers and timebase
	// ----------------------------------------------------------------------------
	logic      xt_s;
	logic      cs1_s;
	logic      cs2_s;
	logic      wr_s;
	logic      rd_s;
	logic      ale_s;
	logic      stop_s;
	nibble_t   bus_s;
	nibble_t   digit [0:`RTC_DIGIT_COUNT-1];
	nibble_t   next_digit [0:`RTC_DIGIT_COUNT-1];
	nibble_t   addr;
	nibble_t   wdata;
	nibble_t   ref_bits;
	bus_mode_t mode;
	logic      enabled;
	logic      count_en;
	logic      min_flag;
	logic      hour_flag;
	logic [8:0] r_sec;
	logic [8:0] r_min;
	logic [8:0] r_hour;
	logic [8:0] r_date;
	logic [8:0] r_month;
	logic [8:0] r_year;
	logic      day_carry;
	logic      next_pm;
	logic      leap;
	bcd2_t     month_last;

	timebase_if tb ();

	pin_sync #(
		.W (11)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_d     ({i_xt, i_power_detect_select, i_host_select, i_write, i_read, i_addr_latch, i_stop, i_nibble_bus}),
		.o_q     ({xt_s, cs1_s, cs2_s, wr_s, rd_s, ale_s, stop_s, bus_s})
	);

	rtc_timebase u_timebase (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_xt    (xt_s),
		.tb      (tb.source)
	);

	// ----------------------------------------------------------------------------
	// Build checks
	// ----------------------------------------------------------------------------
	// The store is indexed by digit offset, so the digit table must end at the year tens digit.
	generate
		if (`RTC_DIGIT_COUNT != `RTC_YEAR_TENS + 1 || `RTC_CODE_REF_LOW <= `RTC_CODE_DIV_RESET)
		begin : g_bad
			$error("Digit table and code map disagree.");
		end
	endgenerate

	// ----------------------------------------------------------------------------
	// Bus mode
	// ----------------------------------------------------------------------------
	// Strobes are levels; a strobe seen with either select low is simply not there.
	assign enabled = cs1_s && cs2_s;

	always_comb
	begin
		if (!enabled)
			mode = BUS_IDLE;
		else if (wr_s)
			mode = BUS_WRITE;
		else if (rd_s)
			mode = BUS_READ;
		else if (ale_s)
			mode = BUS_LATCH;
		else
			mode = BUS_IDLE;
	end

	assign tb.clr_req = mode == BUS_WRITE && addr == `RTC_CODE_DIV_RESET;
	assign count_en   = tb.sec_edge && !(enabled && stop_s);

	// ----------------------------------------------------------------------------
	// Counting chain
	// ----------------------------------------------------------------------------
	assign leap       = is_leap(digit[`RTC_YEAR_TENS], digit[`RTC_YEAR_UNITS],
		{digit[`RTC_DATE_TENS_LEAP][`RTC_LEAP_HI_BIT], digit[`RTC_DATE_TENS_LEAP][`RTC_LEAP_LO_BIT]});
	assign month_last = days_in_month({digit[`RTC_MONTH_TENS], digit[`RTC_MONTH_UNITS]}, leap);

	// Every step is worked out each cycle; the count enable and the carries decide which digits take it.

	always_comb
	begin
		next_digit = digit;
		r_sec      = step2(digit[`RTC_SECONDS_UNITS], digit[`RTC_SECONDS_TENS], 8'h59, 8'h00);
		r_min      = step2(digit[`RTC_MINUTES_UNITS], digit[`RTC_MINUTES_TENS], 8'h59, 8'h00);
		r_date     = step2(digit[`RTC_DATE_UNITS], {2'b00, digit[`RTC_DATE_TENS_LEAP][1:0]}, month_last, 8'h01);
		r_month    = step2(digit[`RTC_MONTH_UNITS], digit[`RTC_MONTH_TENS], 8'h12, 8'h01);
		r_year     = step2(digit[`RTC_YEAR_UNITS], digit[`RTC_YEAR_TENS], 8'h99, 8'h00);
		next_pm    = digit[`RTC_HOURS_TENS_FORMAT][`RTC_HT_PM_BIT];
		day_carry  = 1'b0;
		if (digit[`RTC_HOURS_TENS_FORMAT][`RTC_HT_24H_BIT])
		begin
			r_hour    = step2(digit[`RTC_HOURS_UNITS], {2'b00, digit[`RTC_HOURS_TENS_FORMAT][1:0]}, 8'h23, 8'h00);
			day_carry = r_hour[8];
		end
		else
		begin
			r_hour = step2(digit[`RTC_HOURS_UNITS], {2'b00, digit[`RTC_HOURS_TENS_FORMAT][1:0]}, 8'h12, 8'h01);
			if ({digit[`RTC_HOURS_TENS_FORMAT][1:0], digit[`RTC_HOURS_UNITS]} == 6'h11)
			begin
				next_pm   = !next_pm;
				day_carry = next_pm == 1'b0;
			end
		end
		if (count_en)
		begin
			next_digit[`RTC_SECONDS_UNITS] = r_sec[3:0];
			next_digit[`RTC_SECONDS_TENS]  = r_sec[7:4];
			if (r_sec[8])
			begin
				next_digit[`RTC_MINUTES_UNITS] = r_min[3:0];
				next_digit[`RTC_MINUTES_TENS]  = r_min[7:4];
				if (r_min[8])
				begin
					next_digit[`RTC_HOURS_UNITS]       = r_hour[3:0];
					next_digit[`RTC_HOURS_TENS_FORMAT] = {digit[`RTC_HOURS_TENS_FORMAT][`RTC_HT_24H_BIT],
						next_pm, r_hour[5:4]};
					if (day_carry)
					begin
						next_digit[`RTC_SEVEN_DAY_CYCLE] = (digit[`RTC_SEVEN_DAY_CYCLE] == 4'h6) ? 4'h0
							: digit[`RTC_SEVEN_DAY_CYCLE] + 4'h1;
						next_digit[`RTC_DATE_UNITS]      = r_date[3:0];
						next_digit[`RTC_DATE_TENS_LEAP]  = {digit[`RTC_DATE_TENS_LEAP][3:2], r_date[5:4]};
						if (r_date[8])
						begin
							next_digit[`RTC_MONTH_UNITS] = r_month[3:0];
							next_digit[`RTC_MONTH_TENS]  = r_month[7:4];
							if (r_month[8])
							begin
								next_digit[`RTC_YEAR_UNITS] = r_year[3:0];
								next_digit[`RTC_YEAR_TENS]  = r_year[7:4];
							end
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------------------
	// Write data shaping
	// ----------------------------------------------------------------------------
	always_comb
	begin
		wdata = bus_s & digit_mask(addr);
		if (addr == `RTC_HOURS_TENS_FORMAT && bus_s[`RTC_HT_24H_BIT])
			wdata[`RTC_HT_PM_BIT] = 1'b0;
	end

	// ----------------------------------------------------------------------------
	// Digit store and address latch
	// ----------------------------------------------------------------------------
	// A write in the same cycle as a count step wins for the addressed digit only; software
	// that needs a coherent set of digits holds the stop input while it writes.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < `RTC_DIGIT_COUNT; i++)
				digit[i] <= `RTC_RESET_DIGIT;
			digit[`RTC_DATE_UNITS]  <= `RTC_RESET_DAY_UNITS;
			digit[`RTC_MONTH_UNITS] <= `RTC_RESET_MONTH_UNITS;
		end
		else if (i_ce)
		begin
			digit <= next_digit;
			if (mode == BUS_WRITE && addr <= `RTC_YEAR_TENS)
				digit[addr] <= wdata;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			addr <= 4'h0;
		else if (i_ce && mode == BUS_LATCH)
			addr <= bus_s;
	end

	// ----------------------------------------------------------------------------
	// Reference signals
	// ----------------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			min_flag  <= 1'b0;
			hour_flag <= 1'b0;
		end
		else if (i_ce && tb.sec_edge)
		begin
			min_flag  <= count_en && r_sec[8];
			hour_flag <= count_en && r_sec[8] && r_min[8];
		end
	end

	// The marks are captured at the second edge, so each pulse tells which digits wrapped.
	// A frozen count therefore shows the second pulse alone.
	assign ref_bits = {!(tb.pulse_on && hour_flag), !(tb.pulse_on && min_flag), !tb.pulse_on, tb.sq_1024};

	// ----------------------------------------------------------------------------
	// Bus drive and busy
	// ----------------------------------------------------------------------------
	// Data lines are driven only in read mode, so a select dropping releases them on the third clock edge, after the two synchroniser stages.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			o_nibble_bus <= 4'h0;
			o_nibble_oe  <= 1'b0;
			o_busy_n     <= 1'b1;
		end
		else if (i_ce)
		begin
			o_busy_n <= tb.busy_n;
			case (mode)
				BUS_READ:
				begin
					o_nibble_oe <= 1'b1;
					if (addr >= `RTC_CODE_REF_LOW)
						o_nibble_bus <= ref_bits;
					else if (addr <= `RTC_YEAR_TENS)
						o_nibble_bus <= digit[addr] & digit_mask(addr);
					else
						o_nibble_bus <= 4'h0;
				end
				default:
				begin
					o_nibble_oe  <= 1'b0;
					o_nibble_bus <= 4'h0;
				end
			endcase
		end
	end
endmodule

// file: src/pin_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta;

	generate
		if (W < 1)
		begin : g_bad
			$error("pin_sync width must be positive.");
		end
	endgenerate

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			meta <= '0;
			o_q  <= '0;
		end
		else if (i_ce)
		begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule

// file: src/rtc_timebase.sv
// Crystal divider chain, busy window and reference pulse window.
`timescale 1ns/10ps
`include "rtc_regs.svh"
module rtc_timebase #(
	parameter int STAGES       = `RTC_DIV_STAGES,
	parameter int RESET_STAGES = `RTC_DIV_RESET_STAGES
) (
	input  wire logic     i_clk,
	input  wire logic     i_rst_n,
	input  wire logic     i_ce,
	input  wire logic     i_xt,
	timebase_if.source    tb
);
	localparam int BUSY_TICKS = (`RTC_BUSY_US * `RTC_XTAL_HZ + 999999) / 1000000;
	localparam int REF_TICKS  = (`RTC_REF_PULSE_NS / 100 * `RTC_XTAL_HZ) / 10000000;

	logic              xt_q;
	logic              tick;
	logic [STAGES-1:0] div;
	logic [STAGES-1:0] next_div;
	logic [3:0]        busy_cnt;
	logic [3:0]        ref_cnt;

	generate
		if (STAGES <= RESET_STAGES || STAGES <= `RTC_SQ_STAGE || BUSY_TICKS > 15 || REF_TICKS < 1)
		begin : g_bad
			$error("rtc_timebase parameters out of range.");
		end
	endgenerate

	assign tick     = i_xt && !xt_q;
	assign next_div = div + 1'b1;

	// ----------------------------------------------------------------------------
	// Divider chain
	// ----------------------------------------------------------------------------
	// The last stages clear while the reset code is written, so the second restarts cleanly.
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			xt_q        <= 1'b0;
			div         <= '0;
			tb.sec_edge <= 1'b0;
			tb.sq_1024  <= 1'b0;
		end
		else if (i_ce)
		begin
			xt_q        <= i_xt;
			tb.sq_1024  <= div[`RTC_SQ_STAGE];
			tb.sec_edge <= tick && !tb.clr_req && !div[STAGES-1] && next_div[STAGES-1];
			if (tb.clr_req)
				div[STAGES-1 -: RESET_STAGES] <= '0;
			else if (tick)
				div <= next_div;
		end
	end

	// ----------------------------------------------------------------------------
	// Busy and reference windows
	// ----------------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			busy_cnt    <= '0;
			ref_cnt     <= '0;
			tb.busy_n   <= 1'b1;
			tb.pulse_on <= 1'b0;
		end
		else if (i_ce)
		begin
			if (tb.clr_req)
				busy_cnt <= '0;
			else if (tb.sec_edge)
				busy_cnt <= 4'(BUSY_TICKS);
			else if (tick && busy_cnt != 4'h0)
				busy_cnt <= busy_cnt - 1'b1;
			if (tb.sec_edge)
				ref_cnt <= 4'(REF_TICKS);
			else if (tick && ref_cnt != 4'h0)
				ref_cnt <= ref_cnt - 1'b1;
			tb.busy_n   <= busy_cnt == 4'h0;
			tb.pulse_on <= ref_cnt != 4'h0;
		end
	end
endmodule

// file: tb/nibble_bus_rtc_calendar_tb.sv
// Self-checking bench for the nibble bus calendar clock.
`timescale 1ns/10ps
module nibble_bus_rtc_calendar_tb;
	import rtc_pkg::*;
	logic       i_clk;
	logic       rst_n;
	logic       xt;
	logic [1:0] xt_cnt;
	logic       oe;
	logic       busy_n;
	logic       cs1;
	logic       cs2;
	logic       wr;
	logic       rd;
	logic       ale;
	logic       stop;
	logic       host_en;
	logic       ce;
	nibble_t    bus;
	nibble_t    o_bus;
	nibble_t    host_d;
	nibble_t    got;
	nibble_t    seen_hi;
	nibble_t    seen_lo;
	int         n_mismatch;
	int         checks;
	int         cycles;
	nibble_t rst_tab [13] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};
	nibble_t wr_tab  [13] = '{4'h9, 4'hF, 4'h9, 4'hF, 4'h9, 4'hF, 4'hF, 4'h9, 4'hF, 4'h9, 4'hF, 4'h9, 4'h9};
	nibble_t msk_tab [13] = '{4'h9, 4'h7, 4'h9, 4'h7, 4'h9, 4'hB, 4'h7, 4'h9, 4'hF, 4'h9, 4'h1, 4'h9, 4'h9};
	nibble_t set_tab [13] = '{4'h9, 4'h5, 4'h9, 4'h5, 4'h1, 4'h5, 4'h6, 4'h8, 4'h2, 4'h2, 4'h0, 4'h4, 4'h0};
	nibble_t end_tab [13] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h0, 4'h9, 4'h2, 4'h2, 4'h0, 4'h4, 4'h0};
	// The released bus floats to the pull-up level.
	assign bus = oe ? o_bus : (host_en ? host_d : 4'hF);
	initial i_clk = 1'b0;
	always #20 i_clk = ~i_clk;
	// A crystal at a third of the clock keeps one second inside the run.
	always @(negedge i_clk)
	begin
		xt_cnt <= (xt_cnt == 2'h2) ? 2'h0 : xt_cnt + 2'h1;
		xt     <= (xt_cnt == 2'h2);
	end
	always @(posedge i_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			n_mismatch++;
			final_report();
		end
	end
	nibble_bus_rtc_calendar u_dut (
		.i_clk                 (i_clk),
		.i_rst_n               (rst_n),
		.i_ce                  (ce),
		.i_xt                  (xt),
		.i_power_detect_select (cs1),
		.i_host_select         (cs2),
		.i_write               (wr),
		.i_read                (rd),
		.i_addr_latch          (ale),
		.i_stop                (stop),
		.i_nibble_bus          (bus),
		.o_nibble_bus          (o_bus),
		.o_nibble_oe           (oe),
		.o_busy_n              (busy_n)
	);
	rtc_host u_host (
		.i_clk                 (i_clk),
		.i_nibble_bus          (bus),
		.i_busy_n              (busy_n),
		.o_power_detect_select (cs1),
		.o_host_select         (cs2),
		.o_write               (wr),
		.o_read                (rd),
		.o_addr_latch          (ale),
		.o_stop                (stop),
		.o_drive               (host_d),
		.o_drive_en            (host_en)
	);
	task automatic check(input nibble_t exp, input nibble_t act);
		checks++;
		if (act !== exp)
		begin
			n_mismatch++;
			$display("ERROR %0t exp %h got %h", $time, exp, act);
		end
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		xt_cnt = 2'h0;
		xt = 1'b0;
		n_mismatch = 0;
		checks = 0;
		cycles = 0;
		repeat (4) @(negedge i_clk);
		rst_n = 1'b1;
		for (int a = 0; a < 13; a++)
		begin
			u_host.get(4'(a), got);
			check(rst_tab[a], got);
		end
		u_host.freeze(1'b1);
		for (int a = 0; a < 13; a++)
		begin
			u_host.put(4'(a), wr_tab[a]);
			u_host.get(4'(a), got);
			check(msk_tab[a], got);
		end
		u_host.select(1'b0);
		u_host.put(4'h0, 4'h3);
		u_host.get(4'h0, got);
		check(4'hF, got);
		u_host.select(1'b1);
		u_host.get(4'h0, got);
		check(4'h9, got);
		ce = 1'b0;
		u_host.put(4'h0, 4'h3);
		ce = 1'b1;
		u_host.get(4'h0, got);
		check(4'h9, got);
		u_host.put(4'hD, 4'h0);
		u_host.get(4'hD, got);
		check(4'h0, got);
		for (int a = 0; a < 13; a++)
		begin
			u_host.put(4'(a), set_tab[a]);
			u_host.get(4'(a), got);
			check(set_tab[a], got);
		end
		u_host.freeze(1'b0);
		u_host.hold_read(4'hE);
		for (int i = 0; i < 100000 && busy_n !== 1'b0; i++)
			@(negedge i_clk);
		check(4'h0, {3'h0, busy_n});
		seen_hi = 4'h0;
		seen_lo = 4'h0;
		repeat (100)
		begin
			@(negedge i_clk);
			seen_hi = seen_hi | bus;
			seen_lo = seen_lo | ~bus;
		end
		check(4'hF, seen_hi);
		check(4'hF, seen_lo);
		u_host.end_read();
		for (int a = 0; a < 13; a++)
		begin
			u_host.get(4'(a), got);
			check(end_tab[a], got);
		end
		u_host.get(4'hF, got);
		check(4'hE, got & 4'hE);
		final_report();
	end
endmodule

// file: tb/rtc_checker_assertions.sv
// Port checker for the nibble bus calendar clock.
`timescale 1ns/10ps
module rtc_checker (
	input wire logic             i_clk,
	input wire logic             i_rst_n,
	input wire logic             i_ce,
	input wire logic             i_xt,
	input wire logic             i_power_detect_select,
	input wire logic             i_host_select,
	input wire logic             i_write,
	input wire logic             i_read,
	input wire logic             i_addr_latch,
	input wire logic             i_stop,
	input wire rtc_pkg::nibble_t i_nibble_bus,
	input wire rtc_pkg::nibble_t o_nibble_bus,
	input wire logic             o_nibble_oe,
	input wire logic             o_busy_n
);
	import rtc_pkg::*;
	// ----
	// Helpers
	// ----
	// The bench crystal ticks every third clock, so busy lasts about 24 cycles.
	localparam int BUSY_MIN = 20;
	localparam int BUSY_MAX = 28;
	logic    sel;
	nibble_t addr;
	int      low_cnt;
	assign sel = i_power_detect_select && i_host_select;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			addr <= 4'h0;
		else if (sel && i_addr_latch && !i_write && !i_read)
			addr <= i_nibble_bus;
	end
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n || o_busy_n)
			low_cnt <= 0;
		else
			low_cnt <= low_cnt + 1;
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// ----
	// Assertions
	// ----
	a_busy_length: assert property ($rose(o_busy_n) |-> low_cnt >= BUSY_MIN && low_cnt <= BUSY_MAX)
		else $error("busy low pulse has the wrong length");
	a_busy_bound: assert property (!o_busy_n |-> low_cnt < BUSY_MAX)
		else $error("busy stays low too long");
	a_read_drive: assert property ((i_ce && sel && i_read && !i_write) [*4] |=> o_nibble_oe)
		else $error("read strobe did not drive the bus");
	a_release_bus: assert property ((i_ce && !(sel && i_read)) [*4] |=> !o_nibble_oe && o_nibble_bus == 4'h0)
		else $error("bus not released");
	a_missing_bits: assert property (o_nibble_oe && addr inside {4'h1, 4'h3, 4'h6} |-> !o_nibble_bus[3])
		else $error("absent top bit reads one");
	a_month_tens: assert property (o_nibble_oe && addr == 4'hA |-> o_nibble_bus[3:1] == 3'h0)
		else $error("month tens reads absent bits");
	a_code_d_zero: assert property (o_nibble_oe && addr == 4'hD |-> o_nibble_bus == 4'h0)
		else $error("divider reset code reads nonzero");
	a_format_pm: assert property (o_nibble_oe && addr == 4'h5 && o_nibble_bus[3] |-> !o_nibble_bus[2])
		else $error("PM set in 24 hour mode");
	a_bcd_units: assert property (o_nibble_oe && addr inside {4'h0, 4'h2, 4'h4, 4'h7, 4'h9, 4'hB, 4'hC}
		|-> o_nibble_bus <= 4'h9)
		else $error("units digit above nine");
	a_ref_window: assert property (o_nibble_oe && addr[3:1] == 3'h7 && !o_nibble_bus[1] |-> !o_busy_n)
		else $error("second pulse outside busy time");
	c_busy: cover property ($fell(o_busy_n));
	c_format: cover property (o_nibble_oe && addr == 4'h5);
	c_ref: cover property (o_nibble_oe && addr[3:1] == 3'h7 && !o_nibble_bus[1]);
endmodule
bind nibble_bus_rtc_calendar rtc_checker u_checker (
	.i_clk                 (i_clk),
	.i_rst_n               (i_rst_n),
	.i_ce                  (i_ce),
	.i_xt                  (i_xt),
	.i_power_detect_select (i_power_detect_select),
	.i_host_select         (i_host_select),
	.i_write               (i_write),
	.i_read                (i_read),
	.i_addr_latch          (i_addr_latch),
	.i_stop                (i_stop),
	.i_nibble_bus          (i_nibble_bus),
	.o_nibble_bus          (o_nibble_bus),
	.o_nibble_oe           (o_nibble_oe),
	.o_busy_n              (o_busy_n)
);

// file: tb/rtc_host.sv
// Host processor model driving the nibble bus strobes.
`timescale 1ns/10ps
module rtc_host (
	input  wire logic             i_clk,
	input  wire rtc_pkg::nibble_t i_nibble_bus,
	input  wire logic             i_busy_n,
	output logic                  o_power_detect_select,
	output logic                  o_host_select,
	output logic                  o_write,
	output logic                  o_read,
	output logic                  o_addr_latch,
	output logic                  o_stop,
	output rtc_pkg::nibble_t      o_drive,
	output logic                  o_drive_en
);
	import rtc_pkg::*;
	initial
	begin
		o_power_detect_select = 1'b1;
		o_host_select = 1'b1;
		o_write = 1'b0;
		o_read = 1'b0;
		o_addr_latch = 1'b0;
		o_stop = 1'b0;
		o_drive = 4'h0;
		o_drive_en = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	// Every pin is synchronised, so strobes are held for at least five edges.
	task automatic latch(input nibble_t a);
		@(negedge i_clk);
		o_drive = a;
		o_drive_en = 1'b1;
		o_addr_latch = 1'b1;
		wait_n(5);
		o_addr_latch = 1'b0;
		wait_n(2);
		o_drive_en = 1'b0;
		wait_n(4);
	endtask
	task automatic put(input nibble_t a, input nibble_t d);
		latch(a);
		o_drive = d;
		o_drive_en = 1'b1;
		o_write = 1'b1;
		wait_n(5);
		o_write = 1'b0;
		wait_n(2);
		o_drive_en = 1'b0;
		wait_n(4);
	endtask
	task automatic get(input nibble_t a, output nibble_t d);
		latch(a);
		for (int i = 0; i < 100 && i_busy_n !== 1'b1; i++)
			@(negedge i_clk);
		o_read = 1'b1;
		wait_n(6);
		d = i_nibble_bus;
		o_read = 1'b0;
		wait_n(5);
	endtask
	task automatic hold_read(input nibble_t a);
		latch(a);
		o_read = 1'b1;
	endtask
	task automatic end_read;
		@(negedge i_clk);
		o_read = 1'b0;
		wait_n(5);
	endtask
	task automatic select(input logic v);
		@(negedge i_clk);
		o_host_select = v;
	endtask
	task automatic freeze(input logic v);
		@(negedge i_clk);
		o_stop = v;
	endtask
endmodule
